// File: hw/pmx_pkg.sv
// Notes on behaviour
// - full variant: decoder, pwm and spi pads pick their primary function after reset.
// - during reset pwm and spi output drivers are off and every pad is pulled up.
// - a pad in general-purpose mode has its own direction, independent of neighbours.
// - four pads can show oscillator, system, doubled system and prescaler clocks.
// - spi clock pad drives as master and feeds the clock input as slave.
// - a master presents each master-out bit half a clock before the slave samples.
// - a slave floats master-in while its select is not asserted.
// - a slave presents each master-in bit half a clock before the master samples.
// - in slave mode an asserted select marks the transfer as addressed to this spi.
// - spi master-in and select pads can carry second serial receive and transmit.
// - three pwm pads can carry the second spi select, master-in and master-out.
// - both variants select primary spi clock, data and select after reset.
// - a pad switched to general-purpose mode comes up as an input; here it takes the direction written in the same configuration write.
package pmx_pkg;

    // ------------------------------------------------------------
    // pad indices: port b pads 0..7, port a pads 8..12
    // ------------------------------------------------------------
    localparam int NPAD   = 13;
    localparam int PAD_B0 = 0;   // spi select / serial transmit
    localparam int PAD_B1 = 1;   // spi master-in / serial receive
    localparam int PAD_B2 = 2;   // spi master-out
    localparam int PAD_B3 = 3;   // spi clock
    localparam int PAD_B4 = 4;   // home / timer 3 / prescaler clock
    localparam int PAD_B5 = 5;   // index / timer 2 / system clock
    localparam int PAD_B6 = 6;   // phase b / timer 1 / doubled system clock
    localparam int PAD_B7 = 7;   // phase a / timer 0 / oscillator clock
    localparam int PAD_A0 = 8;   // pwm outputs 0..4 on 8..12
    localparam int PAD_A2 = 10;  // pwm 2 / second spi select
    localparam int PAD_A3 = 11;  // pwm 3 / second spi master-in
    localparam int PAD_A4 = 12;  // pwm 4 / second spi master-out

    localparam logic [NPAD-1:0] CLK_PAD_MASK  = 13'h00f0;
    localparam logic [NPAD-1:0] SPI_PAD_MASK  = 13'h000f;
    localparam logic [NPAD-1:0] RST_DIR       = 13'h0000;  // gpio comes up as input
    localparam logic [NPAD-1:0] RST_GPIO_OUT  = 13'h0000;

    // ------------------------------------------------------------
    // function selection per pad
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_PRI  = 3'h0,
        SEL_ALT  = 3'h1,
        SEL_GPIO = 3'h2,
        SEL_CLK  = 3'h3,
        SEL_NONE = 3'h4
    } pmx_sel_t;

    typedef struct packed {
        pmx_sel_t [NPAD-1:0] sel;
        logic [NPAD-1:0]     dir;   // 1 = output in gpio mode
        logic [NPAD-1:0]     dout;
    } pmx_cfg_t;

    // signals from the internal peripherals toward the pads
    typedef struct packed {
        logic [3:0] timer_o;
        logic [3:0] timer_oe;
        logic [3:0] mon_clk;        // osc, doubled system, system, prescaler (index 0..3)
        logic       spi0_master;
        logic       spi0_sck_o;
        logic       spi0_mosi_o;
        logic       spi0_miso_o;
        logic       spi1_master;
        logic       spi1_mosi_o;
        logic       spi1_miso_o;
        logic       sci1_txd;
        logic [4:0] motor_pwm;
    } pmx_per_out_t;

    // signals from the pads toward the internal peripherals
    typedef struct packed {
        logic            decoder_phase_a;
        logic            decoder_phase_b;
        logic            decoder_index;
        logic            decoder_home;
        logic [3:0]      timer_i;
        logic            spi0_sck_i;
        logic            spi0_mosi_i;
        logic            spi0_miso_i;
        logic            spi0_sel_n;
        logic            sci1_rxd;
        logic            spi1_sel_n;
        logic            spi1_miso_i;
        logic            spi1_mosi_i;
        logic [NPAD-1:0] gpio_i;
    } pmx_per_in_t;

    localparam pmx_per_in_t RST_PER_IN = '{spi0_sel_n: 1'b1, sci1_rxd: 1'b1,
                                           spi1_sel_n: 1'b1, default: '0};

    // reset selection: reduced variant leaves decoder and pwm pads unselected
    function automatic pmx_sel_t [NPAD-1:0] pmx_reset_sel(input bit full);
        pmx_sel_t [NPAD-1:0] s;
        for (int i = 0; i < NPAD; i++) begin
            s[i] = (full || SPI_PAD_MASK[i]) ? SEL_PRI : SEL_NONE;
        end
        return s;
    endfunction : pmx_reset_sel

endpackage : pmx_pkg

// File: hw/pmx_port_pin_mux.sv
`timescale 1ns/100ps
`default_nettype none
module pmx_port_pin_mux
    import pmx_pkg::*;
#(
    parameter bit FULL_FEATURE = 1'b1
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // configuration
    input  wire logic             cfg_wr_in,
    input  wire pmx_cfg_t         cfg_in,
    // peripheral side
    input  wire pmx_per_out_t     per_in,
    output var  pmx_per_in_t      per_out,
    // pad side
    input  wire logic [NPAD-1:0]  pad_in,
    output logic [NPAD-1:0]       pad_out,
    output logic [NPAD-1:0]       pad_oe_out,
    output logic [NPAD-1:0]       pad_pu_out
);

    localparam pmx_sel_t [NPAD-1:0] RST_SEL = pmx_reset_sel(FULL_FEATURE);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_q;

    // async assert, release through two flops
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // selection and drive
    // ------------------------------------------------------------
    pmx_sel_t [NPAD-1:0] sel_q,  sel_d;
    logic [NPAD-1:0]     dir_q,  dir_d;
    logic [NPAD-1:0]     gout_q, gout_d;
    logic [NPAD-1:0]     out_q,  out_d;
    logic [NPAD-1:0]     oe_q,   oe_d;
    logic [NPAD-1:0]     pu_q,   pu_d;
    pmx_per_in_t         pin_q,  pin_d;
    logic [NPAD-1:0]     pri_o, pri_oe, alt_o, alt_oe, clk_o;
    logic                ss0_n, ss1_n;

    // only the chosen function reaches the pad; the rest is ignored
    function automatic logic [1:0] pmx_drive(input pmx_sel_t s, input logic po,
                                             input logic poe, input logic ao,
                                             input logic aoe, input logic goe,
                                             input logic go, input logic co);
        logic [1:0] r;
        r = 2'h0;
        unique case (s)
            SEL_PRI:  r = {poe, po};
            SEL_ALT:  r = {aoe, ao};
            SEL_GPIO: r = {goe, go};
            SEL_CLK:  r = {1'b1, co};
            default:  r = 2'h0;  // unselected or illegal code floats the pad
        endcase
        return r;
    endfunction : pmx_drive

    // next values of configuration, pad drive and peripheral inputs
    always_comb begin
        logic [1:0] d;
        pmx_sel_t   s;
        d      = 2'h0;
        s      = SEL_NONE;
        sel_d  = cfg_wr_in ? cfg_in.sel  : sel_q;
        dir_d  = cfg_wr_in ? cfg_in.dir  : dir_q;
        gout_d = cfg_wr_in ? cfg_in.dout : gout_q;
        // slave selects are read live so master-in floats the same edge
        ss0_n  = (sel_q[PAD_B0] == SEL_PRI) ? pad_in[PAD_B0] : 1'b1;
        ss1_n  = (sel_q[PAD_A2] == SEL_ALT) ? pad_in[PAD_A2] : 1'b1;
        pri_o  = '0;
        pri_oe = '0;
        alt_o  = '0;
        alt_oe = '0;
        clk_o  = '0;
        // decoder pads are inputs in their primary role; timers and monitors as alternates
        for (int k = 0; k < 4; k++) begin
            alt_o[PAD_B7-k]  = per_in.timer_o[k];
            alt_oe[PAD_B7-k] = per_in.timer_oe[k];
            clk_o[PAD_B7-k]  = per_in.mon_clk[k];
        end
        pri_o[PAD_B3]  = per_in.spi0_sck_o;
        pri_oe[PAD_B3] = per_in.spi0_master;
        pri_o[PAD_B2]  = per_in.spi0_mosi_o;
        pri_oe[PAD_B2] = per_in.spi0_master;
        pri_o[PAD_B1]  = per_in.spi0_miso_o;
        pri_oe[PAD_B1] = !per_in.spi0_master && !ss0_n;
        alt_o[PAD_B0]  = per_in.sci1_txd;
        alt_oe[PAD_B0] = 1'b1;
        for (int k = 0; k < 5; k++) begin
            pri_o[PAD_A0+k]  = per_in.motor_pwm[k];
            pri_oe[PAD_A0+k] = 1'b1;
        end
        alt_o[PAD_A3]  = per_in.spi1_miso_o;
        alt_oe[PAD_A3] = !per_in.spi1_master && !ss1_n;
        alt_o[PAD_A4]  = per_in.spi1_mosi_o;
        alt_oe[PAD_A4] = per_in.spi1_master;
        for (int i = 0; i < NPAD; i++) begin
            s = sel_q[i];
            if (s == SEL_CLK && !CLK_PAD_MASK[i]) begin
                s = SEL_NONE;
            end
            d = pmx_drive(s, pri_o[i], pri_oe[i], alt_o[i], alt_oe[i],
                          dir_q[i], gout_q[i], clk_o[i]);
            oe_d[i]  = d[1];
            out_d[i] = d[0];
            pu_d[i]  = !d[1];
        end
        // inputs toward peripherals; deselected ones rest at idle levels
        pin_d                 = RST_PER_IN;
        pin_d.decoder_phase_a = (sel_q[PAD_B7] == SEL_PRI) && pad_in[PAD_B7];
        pin_d.decoder_phase_b = (sel_q[PAD_B6] == SEL_PRI) && pad_in[PAD_B6];
        pin_d.decoder_index   = (sel_q[PAD_B5] == SEL_PRI) && pad_in[PAD_B5];
        pin_d.decoder_home    = (sel_q[PAD_B4] == SEL_PRI) && pad_in[PAD_B4];
        for (int k = 0; k < 4; k++) begin
            pin_d.timer_i[k] = (sel_q[PAD_B7-k] == SEL_ALT) && pad_in[PAD_B7-k];
        end
        pin_d.spi0_sck_i  = (sel_q[PAD_B3] == SEL_PRI) && pad_in[PAD_B3];
        pin_d.spi0_mosi_i = (sel_q[PAD_B2] == SEL_PRI) && pad_in[PAD_B2];
        pin_d.spi0_miso_i = (sel_q[PAD_B1] == SEL_PRI) && pad_in[PAD_B1];
        pin_d.spi0_sel_n  = ss0_n;
        pin_d.sci1_rxd    = (sel_q[PAD_B1] == SEL_ALT) ? pad_in[PAD_B1] : 1'b1;
        pin_d.spi1_sel_n  = ss1_n;
        pin_d.spi1_miso_i = (sel_q[PAD_A3] == SEL_ALT) && pad_in[PAD_A3];
        pin_d.spi1_mosi_i = (sel_q[PAD_A4] == SEL_ALT) && pad_in[PAD_A4];
        for (int i = 0; i < NPAD; i++) begin
            pin_d.gpio_i[i] = (sel_q[i] == SEL_GPIO) && pad_in[i];
        end
    end

    // one flop stage on every path keeps clock and data aligned at the pads
    always_ff @(posedge clk_in or negedge rst_q) begin
        if (!rst_q) begin
            sel_q  <= RST_SEL;
            dir_q  <= RST_DIR;
            gout_q <= RST_GPIO_OUT;
            out_q  <= '0;
            oe_q   <= '0;
            pu_q   <= '1;
            pin_q  <= RST_PER_IN;
        end else begin
            sel_q  <= sel_d;
            dir_q  <= dir_d;
            gout_q <= gout_d;
            out_q  <= out_d;
            oe_q   <= oe_d;
            pu_q   <= pu_d;
            pin_q  <= pin_d;
        end
    end

    assign pad_out    = out_q;
    assign pad_oe_out = oe_q;
    assign pad_pu_out = pu_q;
    assign per_out    = pin_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_gpio_in_wr(int p);
        cfg_wr_in && cfg_in.sel[p] == SEL_GPIO && !cfg_in.dir[p];
    endsequence

    property p_reset_float;
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(rst_q) |-> pad_oe_out == '0 && pad_pu_out == '1;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("pad driven at reset");

    property p_reset_sel;
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(rst_q) |-> sel_q[PAD_B6] == (FULL_FEATURE ? SEL_PRI : SEL_NONE)
                         && sel_q[PAD_A0] == sel_q[PAD_B6];
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("wrong reset selection");

    property p_spi_reset_sel;
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(rst_q) |-> sel_q[PAD_B3] == SEL_PRI && sel_q[PAD_B0] == SEL_PRI;
    endproperty
    a_spi_reset_sel: assert property (p_spi_reset_sel) else $error("spi not primary");

    property p_gpio_input;
        @(posedge clk_in) disable iff (!rst_q)
        s_gpio_in_wr(PAD_B5) ##1 !cfg_wr_in |=> !pad_oe_out[PAD_B5] && pad_pu_out[PAD_B5];
    endproperty
    a_gpio_input: assert property (p_gpio_input) else $error("gpio not input");

    property p_gpio_out;
        @(posedge clk_in) disable iff (!rst_q)
        sel_q[PAD_B4] == SEL_GPIO && dir_q[PAD_B4] && !dir_q[PAD_B5]
        |=> pad_oe_out[PAD_B4] && pad_out[PAD_B4] == $past(gout_q[PAD_B4]);
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("gpio output wrong");

    property p_clk_mon;
        @(posedge clk_in) disable iff (!rst_q)
        sel_q[PAD_B5] == SEL_CLK |=> pad_oe_out[PAD_B5]
                                     && pad_out[PAD_B5] == $past(per_in.mon_clk[2]);
    endproperty
    a_clk_mon: assert property (p_clk_mon) else $error("clock monitor wrong");

    property p_sck_dir;
        @(posedge clk_in) disable iff (!rst_q)
        sel_q[PAD_B3] == SEL_PRI |=> pad_oe_out[PAD_B3] == $past(per_in.spi0_master)
                                     && per_out.spi0_sck_i == $past(pad_in[PAD_B3]);
    endproperty
    a_sck_dir: assert property (p_sck_dir) else $error("spi clock direction");

    property p_mosi_align;
        @(posedge clk_in) disable iff (!rst_q)
        sel_q[PAD_B2] == SEL_PRI && sel_q[PAD_B3] == SEL_PRI && per_in.spi0_master
        |=> pad_out[PAD_B2] == $past(per_in.spi0_mosi_o)
            && pad_out[PAD_B3] == $past(per_in.spi0_sck_o);
    endproperty
    a_mosi_align: assert property (p_mosi_align) else $error("mosi skewed");

    property p_miso_float;
        @(posedge clk_in) disable iff (!rst_q)
        sel_q[PAD_B1] == SEL_PRI && (ss0_n || per_in.spi0_master) |=> !pad_oe_out[PAD_B1];
    endproperty
    a_miso_float: assert property (p_miso_float) else $error("miso driven");

    property p_sel_pass;
        @(posedge clk_in) disable iff (!rst_q)
        sel_q[PAD_B0] == SEL_PRI |=> per_out.spi0_sel_n == $past(pad_in[PAD_B0]);
    endproperty
    a_sel_pass: assert property (p_sel_pass) else $error("select lost");

    property p_rxd_alt;
        @(posedge clk_in) disable iff (!rst_q)
        sel_q[PAD_B1] == SEL_ALT |=> per_out.sci1_rxd == $past(pad_in[PAD_B1])
                                     && !pad_oe_out[PAD_B1];
    endproperty
    a_rxd_alt: assert property (p_rxd_alt) else $error("receive path wrong");

    property p_second_spi_master_out_alt;
        @(posedge clk_in) disable iff (!rst_q)
        sel_q[PAD_A4] == SEL_ALT |=> pad_oe_out[PAD_A4] == $past(per_in.spi1_master);
    endproperty
    a_second_spi_master_out_alt: assert property (p_second_spi_master_out_alt) else $error("second spi out wrong");

endmodule : pmx_port_pin_mux
`default_nettype wire

// File: verif/pmx_pad_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmx_pad_model
    import pmx_pkg::*;
(
    // clock
    input  wire logic            clk_in,
    // device side of the pads
    input  wire logic [NPAD-1:0] pad_out_in,
    input  wire logic [NPAD-1:0] pad_oe_in,
    input  wire logic [NPAD-1:0] pad_pu_in,
    // external drivers
    input  wire logic [NPAD-1:0] ext_val_in,
    input  wire logic [NPAD-1:0] ext_en_in,
    // resolved pad level
    output logic [NPAD-1:0]      pad_lvl_out
);
    logic [NPAD-1:0] last_q = 13'h0000;

    // remember levels so a pad nobody holds does not keep its old value
    always @(posedge clk_in) begin
        last_q <= pad_lvl_out;
    end

    // wire resolution; a clash of two drivers shows as unknown, not as a winner
    always @* begin
        for (int i = 0; i < NPAD; i++) begin
            if (pad_oe_in[i] && ext_en_in[i]) begin
                pad_lvl_out[i] = 1'bx;
            end else if (pad_oe_in[i]) begin
                pad_lvl_out[i] = pad_out_in[i];
            end else if (ext_en_in[i]) begin
                pad_lvl_out[i] = ext_val_in[i];
            end else if (pad_pu_in[i]) begin
                pad_lvl_out[i] = 1'b1;
            end else begin
                pad_lvl_out[i] = ~last_q[i];
            end
        end
    end
endmodule : pmx_pad_model
`default_nettype wire

// File: verif/port_pin_function_mux_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module port_pin_function_mux_tb_top
    import pmx_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic            clk_in    = 1'b0;
    logic            resetn_in = 1'b0;
    logic            cfg_wr_in = 1'b0;
    pmx_cfg_t        cfg_in    = '0;
    pmx_per_out_t    per_in    = '0;
    pmx_per_in_t     per_out;
    logic [NPAD-1:0] pad_in, pad_out, pad_oe_out, pad_pu_out, red_oe;
    logic [NPAD-1:0] ext_val   = 13'h0000;
    logic [NPAD-1:0] ext_en    = 13'h0000;
    int              mismatches   = 0;
    int              total_checks = 0;

    always #2.5 clk_in = ~clk_in;

    pmx_port_pin_mux #(.FULL_FEATURE(1'b1)) pmx_port_pin_mux_inst (.clk_in(clk_in),
        .resetn_in(resetn_in), .cfg_wr_in(cfg_wr_in), .cfg_in(cfg_in), .per_in(per_in),
        .per_out(per_out), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
        .pad_pu_out(pad_pu_out));
    // reduced variant shares every input; only its drive enables are watched
    pmx_port_pin_mux #(.FULL_FEATURE(1'b0)) pmx_port_pin_mux_inst_red (.clk_in(clk_in),
        .resetn_in(resetn_in), .cfg_wr_in(cfg_wr_in), .cfg_in(cfg_in), .per_in(per_in),
        .per_out(), .pad_in(pad_in), .pad_out(), .pad_oe_out(red_oe), .pad_pu_out());
    pmx_pad_model pmx_pad_model_inst (.clk_in(clk_in), .pad_out_in(pad_out),
        .pad_oe_in(pad_oe_out), .pad_pu_in(pad_pu_out), .ext_val_in(ext_val),
        .ext_en_in(ext_en), .pad_lvl_out(pad_in));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [NPAD-1:0] got, input logic [NPAD-1:0] exp, input string w);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc

    function automatic pmx_cfg_t mk(input pmx_sel_t s);
        pmx_cfg_t c;
        c = '0;
        for (int i = 0; i < NPAD; i++) begin
            c.sel[i] = s;
        end
        return c;
    endfunction : mk

    // strobe one cycle; pads follow one edge after the taking edge
    task automatic wr(input pmx_cfg_t c);
        cfg_in = c;
        cfg_wr_in = 1'b1;
        cyc(1);
        cfg_wr_in = 1'b0;
        cyc(2);
    endtask : wr

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        cyc(1);
        chk(pad_oe_out | red_oe, 13'h0000, "oe in reset");
        chk(pad_pu_out, 13'h1fff, "pull-up in reset");
        cyc(7);
        resetn_in = 1'b1;
        ext_en = 13'h00f0;
        ext_val = 13'h0050;
        per_in.motor_pwm = 5'h15;
        cyc(4);
        chk(pad_oe_out, 13'h1f00, "full variant oe");
        chk(red_oe, 13'h0000, "reduced variant oe");
        chk(13'(pad_out[12:8]), 13'h0015, "pwm out");
        chk(13'({per_out.decoder_phase_a, per_out.decoder_phase_b, per_out.decoder_index,
                 per_out.decoder_home}), 13'h0005, "decoder in");
        ext_en = 13'h0000;
    endtask : t_reset

    task automatic t_gpio;
        pmx_cfg_t        c;
        logic [NPAD-1:0] d;
        c = mk(SEL_GPIO);
        wr(c);
        chk(pad_oe_out, 13'h0000, "gpio entry oe");
        for (int k = 0; k < 2; k++) begin
            d = (k == 0) ? 13'h0a5a : 13'h15a5;
            c.dir = d;
            c.dout = 13'h1c63;
            wr(c);
            ext_en = ~d;
            ext_val = 13'h1234;
            cyc(2);
            chk(pad_oe_out, d, "gpio oe");
            chk(pad_pu_out, ~d, "gpio pull-up");
            chk(per_out.gpio_i, (13'h1234 & ~d) | (13'h1c63 & d), "gpio level");
            ext_en = 13'h0000;
        end
    endtask : t_gpio

    task automatic t_clk;
        logic [3:0] p;
        wr(mk(SEL_CLK));
        for (int k = 0; k < 2; k++) begin
            p = (k == 0) ? 4'ha : 4'h5;
            per_in.mon_clk = p;
            cyc(2);
            chk(13'(pad_out[7:4]), 13'({p[0], p[1], p[2], p[3]}), "monitor clocks");
            chk(pad_oe_out, 13'h00f0, "clock pads only");
        end
    endtask : t_clk

    task automatic t_spi;
        wr(mk(SEL_PRI));
        per_in.spi0_master = 1'b1;
        per_in.spi0_sck_o = 1'b1;
        per_in.spi0_mosi_o = 1'b0;
        per_in.spi0_miso_o = 1'b1;
        cyc(2);
        chk(13'(pad_oe_out[3:0]), 13'h000c, "master drive");
        chk(13'(pad_out[3:2]), 13'h0002, "master clock and data");
        per_in.spi0_master = 1'b0;
        cyc(2);
        ext_en = 13'h000d;
        ext_val = 13'h000d;
        cyc(2);
        chk(13'(pad_oe_out[3:0]), 13'h0000, "slave deselected");
        chk(13'({per_out.spi0_sck_i, per_out.spi0_mosi_i, per_out.spi0_sel_n}), 13'h0007,
            "slave inputs");
        ext_val = 13'h000c;
        cyc(2);
        chk(13'({pad_oe_out[1], pad_out[1], per_out.spi0_sel_n}), 13'h0006,
            "slave selected");
        ext_en = 13'h0000;
    endtask : t_spi

    task automatic t_alt;
        pmx_cfg_t c;
        // let the spi slave drive on master-in drop before the pad is driven from outside
        cyc(1);
        c = mk(SEL_PRI);
        for (int k = PAD_B4; k <= PAD_B7; k++) begin
            c.sel[k] = SEL_ALT;
        end
        c.sel[PAD_B0] = SEL_ALT;
        c.sel[PAD_B1] = SEL_ALT;
        c.sel[PAD_A2] = SEL_ALT;
        c.sel[PAD_A3] = SEL_ALT;
        c.sel[PAD_A4] = SEL_ALT;
        ext_en = 13'h0432;
        ext_val = 13'h0010;
        per_in.timer_o = 4'h1;
        per_in.timer_oe = 4'h3;
        per_in.sci1_txd = 1'b1;
        per_in.spi1_master = 1'b1;
        per_in.spi1_mosi_o = 1'b1;
        per_in.motor_pwm = 5'h1f;
        wr(c);
        chk(pad_oe_out, 13'h13c1, "alt oe master");
        chk(pad_out & pad_oe_out, 13'h1381, "alt out master");
        chk(13'(per_out.timer_i), 13'h0009, "timer inputs");
        chk(13'({per_out.sci1_rxd, per_out.spi1_sel_n}), 13'h0000, "alt inputs");
        per_in.spi1_master = 1'b0;
        per_in.spi1_miso_o = 1'b0;
        cyc(2);
        ext_en = 13'h1402;
        ext_val = 13'h1000;
        cyc(2);
        chk(pad_oe_out, 13'h0bc1, "second spi slave oe");
        chk(13'({pad_out[11], per_out.spi1_mosi_i}), 13'h0001, "second spi data");
        ext_val = 13'h1400;
        cyc(2);
        chk(pad_oe_out, 13'h03c1, "second spi deselected");
        resetn_in = 1'b0;
        cyc(1);
        chk(pad_oe_out, 13'h0000, "oe in second reset");
    endtask : t_alt

    // watchdog: a hang counts as a mismatch
    initial begin
        #200us;
        mismatches++;
        give_verdict();
    end

    initial begin
        t_reset();
        t_gpio();
        t_clk();
        t_spi();
        t_alt();
        give_verdict();
    end
endmodule : port_pin_function_mux_tb_top
`default_nettype wire
